// File: src/mdt_top.v
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "mdt_consts.vh"

module mdt_top #(
	parameter NCH = 4
) (
	input wire MCLK,
	input wire SRST,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	input wire SRC_VALID,
	input wire [5:0] SRC_VECTOR,
	output wire SRC_CLAIMED,
	output wire XFER_REQ,
	output reg [1:0] XFER_CH,
	input wire XFER_ACK,
	input wire XFER_LAST,
	output reg [3:0] DMA_END,
	output wire IRQ,
	input wire CPU_ACCEPT,
	input wire [5:0] CPU_ACCEPT_VEC,
	input wire FLAG_CLR,
	input wire [5:0] FLAG_CLR_VEC,
	input wire CPU_VREAD,
	output wire [15:0] CPU_VEC_OFS
);

	localparam ST_IDLE = 2'b01;
	localparam ST_RUN = 2'b10;

	reg [1:0] state;
	reg [3:0] burst_sel;
	reg [3:0] irq_stat;
	reg [3:0] irq_mask;
	reg [1:0] next_ch;
	wire [23:0] vec_flat;
	wire [3:0] trig_pend;
	wire [3:0] soft_req;
	wire [3:0] ready;
	wire [3:0] match;
	wire [3:0] claim;
	wire [3:0] start;
	wire [3:0] last;
	wire [3:0] vec_wr;
	wire soft_wr;
	wire burst_wr;
	wire start_any;
	wire done_last;

	// ----------------------------------------
	// source matching
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < NCH; i = i + 1) begin : g_ch
			wire [5:0] v = vec_flat[6*i +: 6];
			assign match[i] = SRC_VALID && (v != `MDT_VEC_RST) && (v == SRC_VECTOR);
			if (i == 0) begin : g_first
				assign claim[i] = match[i];
			end else begin : g_rest
				assign claim[i] = match[i] && (match[i-1:0] == {i{1'b0}});
			end
			assign vec_wr[i] = REG_WR && (REG_ADDR == (`MDT_OFS_VEC0 + i));
			assign start[i] = start_any && (next_ch == i);
			assign last[i] = done_last && (XFER_CH == i);
			mdt_channel u_ch (
				.clk(MCLK),
				.srst(SRST),
				.vec_wr(vec_wr[i]),
				.vec_wdata(REG_WDATA[5:0]),
				.soft_wr(soft_wr),
				.soft_wdata(REG_WDATA[i]),
				.trig(claim[i]),
				.start(start[i]),
				.last(last[i]),
				.vector(vec_flat[6*i +: 6]),
				.trig_pend(trig_pend[i]),
				.soft_req(soft_req[i]),
				.ready(ready[i])
			);
		end
	endgenerate

	// a claimed source is kept from the cpu as a normal interrupt
	assign SRC_CLAIMED = |match;

	// ----------------------------------------
	// transfer engine
	// ----------------------------------------
	// lowest ready channel is started next
	always @* begin
		if (ready[0]) begin
			next_ch = 2'd0;
		end else if (ready[1]) begin
			next_ch = 2'd1;
		end else if (ready[2]) begin
			next_ch = 2'd2;
		end else begin
			next_ch = 2'd3;
		end
	end

	assign start_any = (state == ST_IDLE) && (|ready);
	assign done_last = (state == ST_RUN) && XFER_ACK && XFER_LAST;
	assign XFER_REQ = (state == ST_RUN);

	// one transfer per trigger; burst holds the engine until the count ends,
	// so other channels wait behind a long burst
	always @(posedge MCLK) begin
		if (SRST) begin
			state <= ST_IDLE;
			XFER_CH <= 2'd0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (start_any) begin
						state <= ST_RUN;
						XFER_CH <= next_ch;
					end
				end
				ST_RUN: begin
					if (XFER_ACK) begin
						if (XFER_LAST || !burst_sel[XFER_CH]) begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	always @(posedge MCLK) begin
		if (SRST) begin
			DMA_END <= `MDT_CH_RST;
		end else begin
			DMA_END <= last;
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	assign soft_wr = REG_WR && (REG_ADDR == `MDT_OFS_SOFT);
	assign burst_wr = REG_WR && (REG_ADDR == `MDT_OFS_BURST);

	always @(posedge MCLK) begin
		if (SRST) begin
			burst_sel <= `MDT_CH_RST;
			irq_mask <= `MDT_CH_RST;
		end else begin
			if (burst_wr) begin
				burst_sel <= REG_WDATA[3:0];
			end
			if (REG_WR && (REG_ADDR == `MDT_OFS_IRQ_MASK)) begin
				irq_mask <= REG_WDATA[3:0];
			end
		end
	end

	// sticky end flags; a new end in the read cycle survives the clear
	always @(posedge MCLK) begin
		if (SRST) begin
			irq_stat <= `MDT_CH_RST;
		end else if (REG_RD && (REG_ADDR == `MDT_OFS_IRQ_STAT)) begin
			irq_stat <= last;
		end else begin
			irq_stat <= irq_stat | last;
		end
	end

	assign IRQ = |(irq_stat & irq_mask);

	// read data registered, unmapped reads answer zero
	always @(posedge MCLK) begin
		if (SRST) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`MDT_OFS_VEC0: REG_RDATA <= {2'b00, vec_flat[5:0]};
				`MDT_OFS_VEC1: REG_RDATA <= {2'b00, vec_flat[11:6]};
				`MDT_OFS_VEC2: REG_RDATA <= {2'b00, vec_flat[17:12]};
				`MDT_OFS_VEC3: REG_RDATA <= {2'b00, vec_flat[23:18]};
				`MDT_OFS_SOFT: REG_RDATA <= {4'h0, soft_req};
				`MDT_OFS_BURST: REG_RDATA <= {4'h0, burst_sel};
				`MDT_OFS_IRQ_STAT: REG_RDATA <= {4'h0, irq_stat};
				`MDT_OFS_IRQ_MASK: REG_RDATA <= {4'h0, irq_mask};
				default: REG_RDATA <= 8'h00;
			endcase
		end else begin
			REG_RDATA <= 8'h00;
		end
	end

	// ----------------------------------------
	// vector read guard
	// ----------------------------------------
	mdt_vector_guard u_guard (
		.clk(MCLK),
		.srst(SRST),
		.accept(CPU_ACCEPT),
		.accept_vec(CPU_ACCEPT_VEC),
		.clr_valid(FLAG_CLR),
		.clr_vec(FLAG_CLR_VEC),
		.vread(CPU_VREAD),
		.vec_ofs(CPU_VEC_OFS)
	);

endmodule // mdt_top
`default_nettype wire

// File: src/mdt_consts.vh
//
// Contract
// - channel vector selects its trigger source
// - counter zero: end interrupt, vector cleared
// - equal vectors: lower channel served first
// - then higher channel takes later triggers
// - burst channel transfers until counter zero
// - burst register bits 3..0, reset zero
// - software request bits 3..0, reset zero
// - cleared flag before vector read: default vector
`ifndef MDT_CONSTS_VH
`define MDT_CONSTS_VH

// register offsets
`define MDT_OFS_VEC0 8'h80
`define MDT_OFS_VEC1 8'h81
`define MDT_OFS_VEC2 8'h82
`define MDT_OFS_VEC3 8'h83
`define MDT_OFS_SOFT 8'h89
`define MDT_OFS_BURST 8'h8a
`define MDT_OFS_IRQ_STAT 8'h8d
`define MDT_OFS_IRQ_MASK 8'h8e

// field layout and reset values
`define MDT_VEC_W 6
`define MDT_VEC_RST 6'h00
`define MDT_CH_RST 4'h0

// vector table: offset is vector times four, default slot offset
`define MDT_VEC_SHIFT 2
`define MDT_DEFAULT_OFS 16'h0008

`endif

// File: src/mdt_channel.v
`timescale 1ns/1ps
`default_nettype none
`include "mdt_consts.vh"

module mdt_channel (
	input wire clk,
	input wire srst,
	input wire vec_wr,
	input wire [5:0] vec_wdata,
	input wire soft_wr,
	input wire soft_wdata,
	input wire trig,
	input wire start,
	input wire last,
	output reg [5:0] vector,
	output reg trig_pend,
	output reg soft_req,
	output wire ready
);

	// a request waits here until the engine grants the channel
	assign ready = trig_pend | soft_req;

	// ----------------------------------------
	// vector register
	// ----------------------------------------
	// a write in the same cycle as completion wins, so a rearm is never lost
	always @(posedge clk) begin
		if (srst) begin
			vector <= `MDT_VEC_RST;
		end else if (vec_wr) begin
			vector <= vec_wdata;
		end else if (last) begin
			vector <= `MDT_VEC_RST;
		end
	end

	// ----------------------------------------
	// trigger and software request
	// ----------------------------------------
	// a new trigger in the start cycle stays pending for the next transfer;
	// completion drops a trigger left over, but a trigger arriving in the completion cycle itself stays pending
	always @(posedge clk) begin
		if (srst) begin
			trig_pend <= 1'b0;
		end else if (trig) begin
			trig_pend <= 1'b1;
		end else if (start || last) begin
			trig_pend <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (srst) begin
			soft_req <= 1'b0;
		end else if (soft_wr) begin
			soft_req <= soft_wdata;
		end else if (start) begin
			soft_req <= 1'b0;
		end
	end

endmodule // mdt_channel
`default_nettype wire

// File: src/mdt_vector_guard.v
`timescale 1ns/1ps
`default_nettype none
`include "mdt_consts.vh"

module mdt_vector_guard (
	input wire clk,
	input wire srst,
	input wire accept,
	input wire [5:0] accept_vec,
	input wire clr_valid,
	input wire [5:0] clr_vec,
	input wire vread,
	output reg [15:0] vec_ofs
);

	reg [5:0] held;
	reg waiting;
	reg lost;

	// ----------------------------------------
	// accept to vector read window
	// ----------------------------------------
	// the cpu fetches the vector a few cycles after accepting; a flag clear
	// landing in between leaves nothing to serve
	always @(posedge clk) begin
		if (srst) begin
			held <= `MDT_VEC_RST;
			waiting <= 1'b0;
			lost <= 1'b0;
			vec_ofs <= 16'h0000;
		end else if (accept) begin
			held <= accept_vec;
			waiting <= 1'b1;
			lost <= clr_valid && (clr_vec == accept_vec);
		end else if (waiting) begin
			if (clr_valid && (clr_vec == held)) begin
				lost <= 1'b1;
			end
			if (vread) begin
				waiting <= 1'b0;
				if (lost || (clr_valid && (clr_vec == held))) begin
					vec_ofs <= `MDT_DEFAULT_OFS;
				end else begin
					vec_ofs <= {8'h00, held, 2'b00};
				end
			end
		end
	end

endmodule // mdt_vector_guard
`default_nettype wire

// File: tb/mdt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdt_consts.vh"
module mdt_monitor (
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic SRC_VALID,
	input wire logic [5:0] SRC_VECTOR,
	input wire logic SRC_CLAIMED,
	input wire logic XFER_REQ,
	input wire logic [1:0] XFER_CH,
	input wire logic XFER_ACK,
	input wire logic XFER_LAST,
	input wire logic [3:0] DMA_END,
	input wire logic IRQ,
	input wire logic CPU_VREAD,
	input wire logic [15:0] CPU_VEC_OFS
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (SRST);
	logic [3:0] bsel;
	// shadow of the burst bits; only software writes them
	always_ff @(posedge MCLK) begin
		if (SRST)
			bsel <= 4'h0;
		else if (REG_WR && REG_ADDR == `MDT_OFS_BURST)
			bsel <= REG_WDATA[3:0];
	end
	AST_ZERO_VEC: assert property (
		SRC_VALID && SRC_VECTOR == 6'h00 |-> !SRC_CLAIMED) else $error("zero vector claimed");
	AST_END_ON_LAST: assert property (
		XFER_REQ && XFER_ACK && XFER_LAST |=> DMA_END == 4'h1 << $past(XFER_CH))
		else $error("no end pulse");
	AST_END_CAUSE: assert property (
		DMA_END != 4'h0 |-> $past(XFER_ACK) && $past(XFER_LAST)) else $error("stray end");
	AST_END_PULSE: assert property (
		DMA_END != 4'h0 |=> DMA_END == 4'h0) else $error("end pulse too long");
	AST_BURST_HOLD: assert property (
		XFER_REQ && XFER_ACK && !XFER_LAST && bsel[XFER_CH] |=> XFER_REQ && $stable(XFER_CH))
		else $error("burst stopped");
	AST_SINGLE_BEAT: assert property (
		XFER_REQ && XFER_ACK && !bsel[XFER_CH] |=> !XFER_REQ) else $error("extra beat");
	AST_RDATA_IDLE: assert property (
		!$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("read data not idle");
	AST_OFS_STANDS: assert property (
		!$past(CPU_VREAD) |-> $stable(CPU_VEC_OFS)) else $error("offset moved");
	AST_IRQ_CAUSE: assert property (
		$rose(IRQ) |-> DMA_END != 4'h0 || $past(REG_WR)) else $error("irq without cause");
	COV_CLAIM: cover property (SRC_VALID && SRC_CLAIMED);
	COV_BURST: cover property (XFER_ACK && !XFER_LAST && bsel != 4'h0);
	COV_END: cover property (DMA_END != 4'h0);
endmodule // mdt_monitor
bind mdt_top mdt_monitor u_mdt_monitor (.MCLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR,
	.REG_RD, .REG_RDATA, .SRC_VALID, .SRC_VECTOR, .SRC_CLAIMED, .XFER_REQ, .XFER_CH,
	.XFER_ACK, .XFER_LAST, .DMA_END, .IRQ, .CPU_VREAD, .CPU_VEC_OFS);
`default_nettype wire

// File: tb/mdt_xfer_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdt_xfer_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic xfer_req,
	input wire logic [1:0] xfer_ch,
	input wire logic [15:0] counts,
	input wire logic [1:0] slow,
	output var logic xfer_ack = 1'h0,
	output var logic xfer_last = 1'h0
);
	logic [3:0] left [4];
	logic [1:0] waited;
	// one beat per request after slow idle cycles; never two beats back to back
	always @(posedge clk) begin
		xfer_ack <= 1'h0;
		xfer_last <= 1'h0;
		if (srst) begin
			waited <= 2'h0;
			for (int i = 0; i < 4; i++)
				left[i] <= counts[4*i +: 4];
		end else if (xfer_req && !xfer_ack && waited == slow) begin
			xfer_ack <= 1'h1;
			xfer_last <= left[xfer_ch] == 4'h1;
			waited <= 2'h0;
			// count spent: reload for the next programmed run
			left[xfer_ch] <= left[xfer_ch] == 4'h1 ? counts[4*xfer_ch +: 4] : left[xfer_ch] - 4'h1;
		end else if (xfer_req && !xfer_ack)
			waited <= waited + 2'h1;
	end
endmodule // mdt_xfer_model
`default_nettype wire

// File: tb/test_mdt_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_mdt_top;
	logic MCLK = 1'h0;
	logic SRST = 1'h1;
	logic [7:0] REG_ADDR = 8'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic REG_WR = 1'h0;
	logic REG_RD = 1'h0;
	logic SRC_VALID = 1'h0;
	logic [5:0] SRC_VECTOR = 6'h00;
	logic CPU_ACCEPT = 1'h0;
	logic [5:0] CPU_ACCEPT_VEC = 6'h00;
	logic FLAG_CLR = 1'h0;
	logic [5:0] FLAG_CLR_VEC = 6'h00;
	logic CPU_VREAD = 1'h0;
	logic [1:0] slow = 2'h0;
	wire [7:0] REG_RDATA;
	wire SRC_CLAIMED, XFER_REQ, XFER_ACK, XFER_LAST, IRQ;
	wire [1:0] XFER_CH;
	wire [3:0] DMA_END;
	wire [15:0] CPU_VEC_OFS;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] regs [8] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h89, 8'h8a, 8'h8e, 8'h90};
	mdt_top u_mdt_top (.MCLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.SRC_VALID, .SRC_VECTOR, .SRC_CLAIMED, .XFER_REQ, .XFER_CH, .XFER_ACK, .XFER_LAST,
		.DMA_END, .IRQ, .CPU_ACCEPT, .CPU_ACCEPT_VEC, .FLAG_CLR, .FLAG_CLR_VEC, .CPU_VREAD,
		.CPU_VEC_OFS);
	// run lengths per channel: ch0 2, ch1 1, ch2 1, ch3 3
	mdt_xfer_model u_mdt_xfer_model (.clk(MCLK), .srst(SRST), .xfer_req(XFER_REQ),
		.xfer_ch(XFER_CH), .counts(16'h3112), .slow(slow), .xfer_ack(XFER_ACK),
		.xfer_last(XFER_LAST));
	always #50 MCLK = ~MCLK;
	// ----
	// bus and handshake tasks
	// ----
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'h1;
		@(posedge MCLK);
		REG_WR <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_RD <= 1'h1;
		@(posedge MCLK);
		REG_RD <= 1'h0;
		@(negedge MCLK);
		chk("register", {8'h00, exp}, {8'h00, REG_RDATA});
	endtask
	task automatic trig(input logic [5:0] v, input logic exp);
		@(posedge MCLK);
		SRC_VALID <= 1'h1;
		SRC_VECTOR <= v;
		@(negedge MCLK);
		chk("claimed", {15'h0, exp}, {15'h0, SRC_CLAIMED});
		@(posedge MCLK);
		SRC_VALID <= 1'h0;
	endtask
	task automatic chk_irq(input logic exp);
		@(negedge MCLK);
		chk("irq", {15'h0, exp}, {15'h0, IRQ});
	endtask
	// bounded wait for a beat (is_end 0) or an end pulse of channel ch
	task automatic wait_ev(input logic is_end, input logic [1:0] ch);
		int k;
		k = 0;
		do begin
			@(negedge MCLK);
			k++;
		end while ((is_end ? DMA_END[ch] : XFER_ACK) !== 1'h1 && k < 100);
		chk("handshake", 16'h1, {15'h0, is_end ? DMA_END[ch] : XFER_ACK});
		if ((is_end ? DMA_END[ch] : XFER_ACK) !== 1'h1)
			give_verdict();
		if (is_end)
			chk("end", {12'h0, 4'h1 << ch}, {12'h0, DMA_END});
		else
			chk("channel", {14'h0, ch}, {14'h0, XFER_CH});
	endtask
	task automatic vec_rd(input logic clr, input logic [15:0] exp);
		@(posedge MCLK);
		CPU_ACCEPT <= 1'h1;
		CPU_ACCEPT_VEC <= 6'h0a;
		@(posedge MCLK);
		CPU_ACCEPT <= 1'h0;
		// clear issued with interrupts off, the vector read follows in the next cycle
		FLAG_CLR <= clr;
		FLAG_CLR_VEC <= 6'h0a;
		@(posedge MCLK);
		FLAG_CLR <= 1'h0;
		CPU_VREAD <= 1'h1;
		@(posedge MCLK);
		CPU_VREAD <= 1'h0;
		@(negedge MCLK);
		chk("vector offset", exp, CPU_VEC_OFS);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		repeat (2) @(posedge MCLK);
		SRST <= 1'h0;
		foreach (regs[i])
			rd(regs[i], 8'h00);
		wr(8'h8e, 8'h0f);
		wr(8'h81, 8'h0a);
		trig(6'h00, 1'h0);
		trig(6'h0a, 1'h1);
		wait_ev(1'h0, 2'h1);
		wait_ev(1'h1, 2'h1);
		trig(6'h0a, 1'h0);
		rd(8'h81, 8'h00);
		chk_irq(1'h1);
		rd(8'h8d, 8'h02);
		chk_irq(1'h0);
		wr(8'h81, 8'h0a);
		trig(6'h0a, 1'h1);
		wait_ev(1'h1, 2'h1);
		// equal vectors: ch0 runs out, then ch2 takes over
		wr(8'h80, 8'h15);
		wr(8'h82, 8'h15);
		for (int n = 0; n < 3; n++) begin
			trig(6'h15, 1'h1);
			wait_ev(1'h0, n < 2 ? 2'h0 : 2'h2);
		end
		wait_ev(1'h1, 2'h2);
		// burst on ch3 with a slow transfer unit
		slow <= 2'h2;
		wr(8'h8a, 8'h08);
		wr(8'h83, 8'h20);
		trig(6'h20, 1'h1);
		repeat (3) wait_ev(1'h0, 2'h3);
		wait_ev(1'h1, 2'h3);
		rd(8'h8a, 8'h08);
		// software requests with the end event masked
		wr(8'h8e, 8'h00);
		rd(8'h8d, 8'h0f);
		wr(8'h80, 8'h11);
		wr(8'h89, 8'h01);
		wait_ev(1'h0, 2'h0);
		rd(8'h89, 8'h00);
		wr(8'h89, 8'h01);
		wait_ev(1'h1, 2'h0);
		chk_irq(1'h0);
		wr(8'h8e, 8'h01);
		chk_irq(1'h1);
		rd(8'h8d, 8'h01);
		chk_irq(1'h0);
		vec_rd(1'h0, 16'h0028);
		vec_rd(1'h1, 16'h0008);
		give_verdict();
	end
endmodule // test_mdt_top
`default_nettype wire
